// ===== rtl/edd_dma.sv
// Purpose: descriptor engine between the MAC and system memory
// Assumes: memory slave answers with a one-cycle ack, read data beside it
// Notes: receive and transmit share one memory port, one at a time
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module edd_dma
   import edd_pkg::*;
(
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic CE,
   input wire logic [7:0] REG_ADDR,
   input wire logic [DW-1:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [DW-1:0] REG_RDATA,
   output edd_mem_s MEM_CMD,
   input wire logic MEM_ACK,
   input wire logic [DW-1:0] MEM_RDATA,
   input wire logic RX_VALID,
   input wire logic [DW-1:0] RX_DATA,
   input wire logic RX_EOF,
   input wire logic RX_TOSS,
   output logic RX_READY,
   output logic TX_VALID,
   output logic [DW-1:0] TX_DATA,
   output logic TX_LAST,
   input wire logic TX_READY,
   input wire logic TX_DONE,
   input wire logic [12:0] TX_STATUS,
   input wire logic MAC_HALT_IMMEDIATE,
   input wire logic MAC_TX_ENABLE
);

////////////////////////////////////////////////////////////////////////
function automatic logic [DW-1:0] daddr(
   input logic [DW-1:0] base,
   input logic [3:0] idx
);
   daddr = base + {25'h0, idx, 3'h0};
endfunction

function automatic logic [3:0] nidx(
   input logic [3:0] idx,
   input logic [3:0] cfg
);
   if (({1'b0, idx} + 5'h01) >= {1'b0, cfg})
      nidx = 4'h0;
   else
      nidx = idx + 4'h1;
endfunction

function automatic edd_mem_s mcmd(
   input logic we,
   input logic [DW-1:0] a,
   input logic [DW-1:0] d
);
   mcmd.req = 1'b1;
   mcmd.we = we;
   mcmd.addr = a;
   mcmd.wdata = d;
endfunction

////////////////////////////////////////////////////////////////////////
logic [DW-1:0] rx_dma_control_reg;
logic [DW-1:0] tx_dma_control_reg;
logic [DW-1:0] rx_length_reg;
logic [DW-1:0] rx_descriptor_pointer_reg;
logic [DW-1:0] tx_descriptor_pointer_reg;
logic [LW-1:0] rx_frame_count_reg;
logic [LW-1:0] tx_frame_count_reg;
logic rx_halted;
logic tx_halted;
edd_state_e state;
logic [3:0] rx_idx;
logic [3:0] tx_idx;
logic [DW-1:0] first_addr;
logic [DW-1:0] wr_addr;
logic [DW-1:0] last_addr;
logic [LW-1:0] total;
logic [LW-1:0] buf_bytes;
logic first;
logic ovf;
logic eof_l;
logic err_l;
logic [LW:0] remain;
logic [LW-1:0] tx_len;
logic [1:0] tx_wid;
logic held;
logic ack;
logic fire;
logic rx_dma_enable;
logic tx_en;
logic [3:0] rx_descriptor_count_cfg;
logic [3:0] tx_descriptor_count_cfg;
logic [LW-1:0] rx_max_frame_size;
logic [LW-1:0] rx_buf_size;
logic [DW-1:0] rx_w1;
logic [DW-1:0] tx_w1;
logic [3:0] rx_n;
logic [3:0] tx_n;

assign ack = MEM_CMD.req && MEM_ACK;
assign fire = RX_READY && RX_VALID;
assign rx_dma_enable = rx_dma_control_reg[C_EN];
assign tx_en = tx_dma_control_reg[C_EN];
assign rx_descriptor_count_cfg = rx_dma_control_reg[3:0];
assign tx_descriptor_count_cfg = tx_dma_control_reg[3:0];
assign rx_max_frame_size = rx_length_reg[LW-1:0];
assign rx_buf_size = rx_length_reg[DW-1:LW];
assign rx_n = nidx(rx_idx, rx_descriptor_count_cfg);
assign tx_n = nidx(tx_idx, tx_descriptor_count_cfg);
// receive word 1 as written back: ownership handed to software
assign rx_w1 = {1'b0, 1'b0, first, eof_l, 6'h0, err_l && eof_l,
   ovf, 4'h0, total};
assign tx_w1 = {1'b0, TX_STATUS[12:11], TX_STATUS[10] | held,
   TX_STATUS[9:0], tx_wid, tx_len};

////////////////////////////////////////////////////////////////////////
// software registers; pointers are never moved by the engine
always_ff @(posedge CLK)
begin
   if (SYS_RST)
   begin
      rx_dma_control_reg <= '0;
      tx_dma_control_reg <= '0;
      rx_length_reg <= RXLEN_RST;
      rx_descriptor_pointer_reg <= '0;
      tx_descriptor_pointer_reg <= '0;
   end
   else if (CE && REG_WR)
   begin
      unique case (REG_ADDR)
         A_RXCTL: rx_dma_control_reg <= REG_WDATA;
         A_TXCTL: tx_dma_control_reg <= REG_WDATA;
         A_RXLEN: rx_length_reg <= REG_WDATA;
         A_RXPTR: rx_descriptor_pointer_reg <= REG_WDATA;
         A_TXPTR: tx_descriptor_pointer_reg <= REG_WDATA;
         default: ;
      endcase
   end
end

always_ff @(posedge CLK)
begin
   if (SYS_RST)
      REG_RDATA <= '0;
   else if (CE)
   begin
      REG_RDATA <= '0;
      if (REG_RD)
      begin
         unique case (REG_ADDR)
            A_RXCTL: REG_RDATA <= rx_dma_control_reg;
            A_TXCTL: REG_RDATA <= tx_dma_control_reg;
            A_RXLEN: REG_RDATA <= rx_length_reg;
            A_RXPTR: REG_RDATA <= rx_descriptor_pointer_reg;
            A_TXPTR: REG_RDATA <= tx_descriptor_pointer_reg;
            A_RXCNT: REG_RDATA <= {16'h0, rx_frame_count_reg};
            A_TXCNT: REG_RDATA <= {16'h0, tx_frame_count_reg};
            A_STAT: REG_RDATA <= {3'h0, state, 14'h0, tx_halted,
               rx_halted};
            default: REG_RDATA <= '0;
         endcase
      end
   end
end

////////////////////////////////////////////////////////////////////////
// halt flags: a control write with enable set clears, a new halt wins
always_ff @(posedge CLK)
begin
   if (SYS_RST)
   begin
      rx_halted <= 1'b0;
      tx_halted <= 1'b0;
   end
   else if (CE)
   begin
      if (REG_WR && REG_ADDR == A_RXCTL && REG_WDATA[C_EN])
         rx_halted <= 1'b0;
      if (REG_WR && REG_ADDR == A_TXCTL && REG_WDATA[C_EN])
         tx_halted <= 1'b0;
      if (state == S_RDESC && ack && !MEM_RDATA[B_OWN]
         && !MEM_RDATA[B_SKIP] && rx_dma_control_reg[C_HOPT])
         rx_halted <= 1'b1;
      if (state == S_TDESC && ack && !MEM_RDATA[B_OWN]
         && tx_dma_control_reg[C_HOPT])
         tx_halted <= 1'b1;
   end
end

////////////////////////////////////////////////////////////////////////
// engine: one memory access at a time, request held until ack
always_ff @(posedge CLK)
begin
   if (SYS_RST)
   begin
      state <= S_IDLE;
      MEM_CMD <= '0;
      RX_READY <= 1'b0;
      TX_VALID <= 1'b0;
      TX_DATA <= '0;
      TX_LAST <= 1'b0;
      rx_idx <= 4'h0;
      tx_idx <= 4'h0;
      rx_frame_count_reg <= '0;
      tx_frame_count_reg <= '0;
      first_addr <= '0;
      wr_addr <= '0;
      last_addr <= '0;
      total <= '0;
      buf_bytes <= '0;
      first <= 1'b0;
      ovf <= 1'b0;
      eof_l <= 1'b0;
      err_l <= 1'b0;
      remain <= '0;
      tx_len <= '0;
      tx_wid <= 2'h0;
      held <= 1'b0;
   end
   else if (CE)
   begin
      if (ack)
         MEM_CMD.req <= 1'b0;
      unique case (state)
         S_IDLE:
         begin
            // receive waits for the MAC to offer data so transmit is not starved
            if (rx_dma_enable && !rx_halted && RX_VALID)
            begin
               first <= 1'b1;
               total <= '0;
               ovf <= 1'b0;
               eof_l <= 1'b0;
               err_l <= 1'b0;
               MEM_CMD <= mcmd(1'b0, daddr(rx_descriptor_pointer_reg,
                  rx_idx) + DESC_W1, '0);
               state <= S_RDESC;
            end
            else if (tx_en && !tx_halted)
            begin
               held <= 1'b0;
               MEM_CMD <= mcmd(1'b0, daddr(tx_descriptor_pointer_reg,
                  tx_idx) + DESC_W1, '0);
               state <= S_TDESC;
            end
         end
         S_RDESC:
         if (ack)
         begin
            if (MEM_RDATA[B_OWN])
            begin
               if (first)
                  first_addr <= MEM_CMD.addr;
               MEM_CMD <= mcmd(1'b0, MEM_CMD.addr - DESC_W1, '0);
               state <= S_RPTR;
            end
            else
            begin
               rx_idx <= rx_n;
               if (rx_n == 4'h0)
                  rx_frame_count_reg <= '0;
               if (MEM_RDATA[B_SKIP] || !rx_dma_control_reg[C_HOPT])
               begin
                  MEM_CMD <= mcmd(1'b0, daddr(rx_descriptor_pointer_reg,
                     rx_n) + DESC_W1, '0);
               end
               else
                  state <= S_IDLE;
            end
         end
         S_RPTR:
         if (ack)
         begin
            wr_addr <= MEM_RDATA;
            buf_bytes <= '0;
            RX_READY <= 1'b1;
            state <= S_RDATA;
         end
         S_RDATA:
         begin
            if (fire)
            begin
               RX_READY <= 1'b0;
               eof_l <= RX_EOF;
               err_l <= RX_TOSS;
               if (ovf || (total + WORD_B) > rx_max_frame_size)
               begin
                  ovf <= 1'b1;
                  MEM_CMD <= mcmd(1'b1, last_addr, RX_DATA);
               end
               else
               begin
                  MEM_CMD <= mcmd(1'b1, wr_addr, RX_DATA);
                  last_addr <= wr_addr;
                  wr_addr <= wr_addr + WORD;
                  total <= total + WORD_B;
                  buf_bytes <= buf_bytes + WORD_B;
               end
            end
            if (ack)
            begin
               // frame end or buffer full: close this descriptor, chain on unless the frame ended
               if (eof_l || (!ovf && buf_bytes >= rx_buf_size))
               begin
                  MEM_CMD <= mcmd(1'b1, daddr(rx_descriptor_pointer_reg,
                     rx_idx) + DESC_W1, rx_w1);
                  state <= S_RWB;
               end
               else
                  RX_READY <= 1'b1;
            end
         end
         S_RWB:
         if (ack)
         begin
            rx_idx <= rx_n;
            if (rx_n == 4'h0)
               rx_frame_count_reg <= '0;
            if (!eof_l)
            begin
               first <= 1'b0;
               MEM_CMD <= mcmd(1'b0, daddr(rx_descriptor_pointer_reg,
                  rx_n) + DESC_W1, '0);
               state <= S_RDESC;
            end
            else if (!first)
            begin
               MEM_CMD <= mcmd(1'b1, first_addr, {3'b001, 1'b1, 1'b1,
                  rx_w1[26:0]});
               state <= S_RWBF;
            end
            else
            begin
               if (rx_n != 4'h0)
                  rx_frame_count_reg <= rx_frame_count_reg + 16'h0001;
               state <= S_IDLE;
            end
         end
         S_RWBF:
         if (ack)
         begin
            if (rx_idx != 4'h0)
               rx_frame_count_reg <= rx_frame_count_reg + 16'h0001;
            state <= S_IDLE;
         end
         S_TDESC:
         if (ack)
         begin
            if (MEM_RDATA[B_OWN])
            begin
               tx_len <= MEM_RDATA[LW-1:0];
               tx_wid <= MEM_RDATA[T_WID_LO+1:T_WID_LO];
               remain <= {1'b0, MEM_RDATA[LW-1:0]}
                  + {15'h0, MEM_RDATA[T_WID_LO+1:T_WID_LO]};
               MEM_CMD <= mcmd(1'b0, MEM_CMD.addr - DESC_W1, '0);
               state <= S_TPTR;
            end
            else
            begin
               if (!tx_dma_control_reg[C_HOPT])
               begin
                  tx_idx <= tx_n;
                  if (tx_n == 4'h0)
                     tx_frame_count_reg <= '0;
               end
               state <= S_IDLE;
            end
         end
         S_TPTR:
         if (ack)
         begin
            wr_addr <= MEM_RDATA;
            if (MAC_HALT_IMMEDIATE || !MAC_TX_ENABLE)
            begin
               held <= 1'b1;
               MEM_CMD <= mcmd(1'b1, daddr(tx_descriptor_pointer_reg,
                  tx_idx) + DESC_W1, {1'b1, 2'h0, 1'b1, 10'h0, tx_wid,
                  tx_len});
               state <= S_THOLD;
            end
            else
            begin
               MEM_CMD <= mcmd(1'b0, MEM_RDATA, '0);
               state <= S_TRD;
            end
         end
         S_THOLD:
         // descriptor stays owned while the MAC holds the frame back
         if (!MEM_CMD.req && MAC_TX_ENABLE && !MAC_HALT_IMMEDIATE)
         begin
            MEM_CMD <= mcmd(1'b0, wr_addr, '0);
            state <= S_TRD;
         end
         S_TRD:
         if (ack)
         begin
            TX_DATA <= MEM_RDATA;
            TX_VALID <= 1'b1;
            TX_LAST <= remain <= 17'h00004;
            wr_addr <= wr_addr + WORD;
            remain <= (remain > 17'h00004) ? remain - 17'h00004 : '0;
            state <= S_TOUT;
         end
         S_TOUT:
         if (TX_VALID && TX_READY)
         begin
            TX_VALID <= 1'b0;
            TX_LAST <= 1'b0;
            if (remain == '0)
               state <= S_TWAIT;
            else
            begin
               MEM_CMD <= mcmd(1'b0, wr_addr, '0);
               state <= S_TRD;
            end
         end
         S_TWAIT:
         if (TX_DONE)
         begin
            MEM_CMD <= mcmd(1'b1, daddr(tx_descriptor_pointer_reg,
               tx_idx) + DESC_W1, tx_w1);
            state <= S_TWB;
         end
         S_TWB:
         if (ack)
         begin
            tx_idx <= tx_n;
            if (tx_n == 4'h0)
               tx_frame_count_reg <= '0;
            else
               tx_frame_count_reg <= tx_frame_count_reg + 16'h0001;
            state <= S_IDLE;
         end
      endcase
   end
end

endmodule
`default_nettype wire

// ===== rtl/edd_pkg.sv
// Purpose: shared constants and types of the descriptor DMA
// Assumes: 32-bit memory words, 8-byte descriptors
// Notes: register offsets are byte addresses on the plain port
package edd_pkg;
   localparam int DW = 32;
   localparam int LW = 16;
   localparam logic [7:0] A_RXCTL = 8'h00;
   localparam logic [7:0] A_TXCTL = 8'h04;
   localparam logic [7:0] A_RXLEN = 8'h08;
   localparam logic [7:0] A_RXPTR = 8'h0c;
   localparam logic [7:0] A_TXPTR = 8'h10;
   localparam logic [7:0] A_RXCNT = 8'h14;
   localparam logic [7:0] A_TXCNT = 8'h18;
   localparam logic [7:0] A_STAT = 8'h1c;
   localparam int C_EN = 10;
   localparam int C_HOPT = 11;
   localparam int B_OWN = 31;
   localparam int B_SKIP = 30;
   localparam int B_SOF = 29;
   localparam int B_EOF = 28;
   localparam int B_DONE = 27;
   localparam int B_RXERR = 21;
   localparam int B_OVF = 20;
   localparam int B_THALT = 28;
   localparam int T_ST_LO = 18;
   localparam int T_WID_LO = 16;
   localparam logic [31:0] DESC_W1 = 32'h0000_0004;
   localparam logic [31:0] WORD = 32'h0000_0004;
   localparam logic [15:0] WORD_B = 16'h0004;
   localparam logic [31:0] RXLEN_RST = 32'h0040_05ee;
   typedef struct packed {
      logic req;
      logic we;
      logic [DW-1:0] addr;
      logic [DW-1:0] wdata;
   } edd_mem_s;
   typedef enum logic [12:0] {
      S_IDLE = 13'b0000000000001,
      S_RDESC = 13'b0000000000010,
      S_RPTR = 13'b0000000000100,
      S_RDATA = 13'b0000000001000,
      S_RWB = 13'b0000000010000,
      S_RWBF = 13'b0000000100000,
      S_TDESC = 13'b0000001000000,
      S_TPTR = 13'b0000010000000,
      S_THOLD = 13'b0000100000000,
      S_TRD = 13'b0001000000000,
      S_TOUT = 13'b0010000000000,
      S_TWAIT = 13'b0100000000000,
      S_TWB = 13'b1000000000000
   } edd_state_e;
endpackage

// ===== verif/edd_dma_props.sv
// Purpose: port-level checks of the descriptor engine
// Assumes: CE dropped only while the engine is idle
// Notes: bound to every edd_dma instance
`timescale 1ns/100ps
`default_nettype none
module edd_dma_props
   import edd_pkg::*;
(
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic CE,
   input wire logic [7:0] REG_ADDR,
   input wire logic [DW-1:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [DW-1:0] REG_RDATA,
   input wire edd_mem_s MEM_CMD,
   input wire logic MEM_ACK,
   input wire logic [DW-1:0] MEM_RDATA,
   input wire logic RX_VALID,
   input wire logic [DW-1:0] RX_DATA,
   input wire logic RX_EOF,
   input wire logic RX_TOSS,
   input wire logic RX_READY,
   input wire logic TX_VALID,
   input wire logic [DW-1:0] TX_DATA,
   input wire logic TX_LAST,
   input wire logic TX_READY,
   input wire logic TX_DONE,
   input wire logic [12:0] TX_STATUS,
   input wire logic MAC_HALT_IMMEDIATE,
   input wire logic MAC_TX_ENABLE
);
   logic [DW-1:0] rx_cap;
   logic [DW-1:0] ptr_w;
   logic [12:0] st_cap;
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   always_ff @(posedge CLK)
   begin
      if (RX_READY && RX_VALID)
         rx_cap <= RX_DATA;
   end
   always_ff @(posedge CLK)
   begin
      if (TX_DONE)
         st_cap <= TX_STATUS;
   end
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
         ptr_w <= 32'h0;
      else if (CE && REG_WR && REG_ADDR == A_RXPTR)
         ptr_w <= REG_WDATA;
   end
   ////////////////////////////////////////////////////////////
   mem_hold_a: assert property (MEM_CMD.req && !MEM_ACK |=> $stable(MEM_CMD))
      else $error("memory request changed before ack");
   ready_quiet_a: assert property (RX_READY |-> !MEM_CMD.req)
      else $error("receive ready while memory busy");
   take_drop_a: assert property (RX_READY && RX_VALID |=> !RX_READY)
      else $error("receive ready stayed up after a take");
   rx_write_a: assert property (RX_READY && RX_VALID |-> ##[1:3] (MEM_CMD.req && MEM_CMD.we && MEM_CMD.wdata == rx_cap))
      else $error("taken word not written to memory");
   tx_hold_a: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA) && $stable(TX_LAST))
      else $error("transmit word dropped while stalled");
   tx_last_a: assert property (TX_LAST |-> TX_VALID)
      else $error("last flag without valid");
   tx_gate_a: assert property ($rose(TX_VALID) |-> MAC_TX_ENABLE && !MAC_HALT_IMMEDIATE)
      else $error("transmit started while held");
   tx_wb_a: assert property (TX_DONE |-> ##[1:8] (MEM_CMD.req && MEM_CMD.we && !MEM_CMD.wdata[31]
      && MEM_CMD.wdata[27:18] == st_cap[9:0] && MEM_CMD.wdata[30:29] == st_cap[12:11]))
      else $error("transmit status not written back");
   ptr_fixed_a: assert property (CE && REG_RD && REG_ADDR == A_RXPTR |=> REG_RDATA == ptr_w)
      else $error("receive pointer register moved");
endmodule
bind edd_dma edd_dma_props edd_dma_props_i (.CLK(CLK), .SYS_RST(SYS_RST), .CE(CE), .REG_ADDR(REG_ADDR),
   .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .MEM_CMD(MEM_CMD),
   .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA), .RX_VALID(RX_VALID), .RX_DATA(RX_DATA), .RX_EOF(RX_EOF),
   .RX_TOSS(RX_TOSS), .RX_READY(RX_READY), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_LAST(TX_LAST),
   .TX_READY(TX_READY), .TX_DONE(TX_DONE), .TX_STATUS(TX_STATUS), .MAC_HALT_IMMEDIATE(MAC_HALT_IMMEDIATE),
   .MAC_TX_ENABLE(MAC_TX_ENABLE));
`default_nettype wire

// ===== verif/edd_mem_model.sv
// Purpose: system memory holding descriptor rings and frame buffers
// Assumes: one access at a time, word addressed by addr[13:2]
// Notes: slow adds wait cycles; read data toggle outside ack
`timescale 1ns/100ps
`default_nettype none
module edd_mem_model
   import edd_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire edd_mem_s mem_cmd,
   input wire logic slow,
   output logic mem_ack,
   output logic [DW-1:0] mem_rdata
);
   logic [DW-1:0] mem [0:4095];
   logic [1:0] cnt;
   ////////////////////////////////////////////////////////////
   // plain always: the bench also writes mem as software does
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         mem_ack <= 1'b0;
         cnt <= 2'h0;
         mem_rdata <= 32'h0;
      end
      else if (mem_cmd.req && !mem_ack && cnt >= (slow ? 2'h3 : 2'h0))
      begin
         mem_ack <= 1'b1;
         cnt <= 2'h0;
         if (mem_cmd.we)
            mem[mem_cmd.addr[13:2]] <= mem_cmd.wdata;
         else
            mem_rdata <= mem[mem_cmd.addr[13:2]];
      end
      else
      begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
         if (mem_cmd.req && !mem_ack)
            cnt <= cnt + 2'h1;
      end
   end
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// Purpose: register and stream sequences against the descriptor engine
// Assumes: bench plays software; memory model holds the rings
// Notes: CE dropped once around a register write, high otherwise
`timescale 1ns/100ps
`default_nettype none
module tb_top
   import edd_pkg::*;
;
   logic CLK, SYS_RST, CE, REG_WR, REG_RD, MEM_ACK, RX_VALID, RX_EOF, RX_TOSS, RX_READY, TX_VALID, TX_LAST;
   logic TX_READY, TX_DONE, MAC_HALT_IMMEDIATE, MAC_TX_ENABLE, slow;
   logic [7:0] REG_ADDR;
   logic [DW-1:0] REG_WDATA, REG_RDATA, MEM_RDATA, RX_DATA, TX_DATA;
   logic [12:0] TX_STATUS;
   edd_mem_s MEM_CMD;
   int miscompares, tests_run, t;
   edd_dma edd_dma_i (.CLK(CLK), .SYS_RST(SYS_RST), .CE(CE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
      .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .MEM_CMD(MEM_CMD), .MEM_ACK(MEM_ACK),
      .MEM_RDATA(MEM_RDATA), .RX_VALID(RX_VALID), .RX_DATA(RX_DATA), .RX_EOF(RX_EOF), .RX_TOSS(RX_TOSS),
      .RX_READY(RX_READY), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_LAST(TX_LAST), .TX_READY(TX_READY),
      .TX_DONE(TX_DONE), .TX_STATUS(TX_STATUS), .MAC_HALT_IMMEDIATE(MAC_HALT_IMMEDIATE),
      .MAC_TX_ENABLE(MAC_TX_ENABLE));
   edd_mem_model edd_mem_model_i (.clk(CLK), .sys_rst(SYS_RST), .mem_cmd(MEM_CMD), .slow(slow),
      .mem_ack(MEM_ACK), .mem_rdata(MEM_RDATA));
   ////////////////////////////////////////////////////////////
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e)
      begin
         miscompares++;
         $display("MISMATCH %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      REG_ADDR <= a;
      REG_WDATA <= d;
      REG_WR <= 1'b1;
      @(posedge CLK);
      REG_WR <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge CLK);
      REG_ADDR <= a;
      REG_RD <= 1'b1;
      @(posedge CLK);
      REG_RD <= 1'b0;
      #1 cmp(REG_RDATA & m, e);
   endtask
   task automatic mw(input logic [31:0] a, input logic [31:0] d);
      edd_mem_model_i.mem[a[13:2]] = d;
   endtask
   task automatic mc(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
      cmp(edd_mem_model_i.mem[a[13:2]] & m, e);
   endtask
   // software sees ownership return; extra cycles let the first descriptor be rewritten
   task automatic wown(input logic [31:0] a);
      t = 0;
      while (edd_mem_model_i.mem[a[13:2]][31] !== 1'b0 && t < 600)
      begin
         @(negedge CLK);
         t++;
      end
      repeat (20) @(negedge CLK);
   endtask
   task automatic rx_frame(input int n, input logic [31:0] b, input logic toss);
      for (int k = 0; k < n; k++)
      begin
         RX_VALID <= 1'b1;
         RX_DATA <= b + k;
         RX_EOF <= (k == n - 1);
         RX_TOSS <= toss && (k == n - 1);
         t = 0;
         do
         begin
            @(negedge CLK);
            t++;
         end
         while (RX_READY !== 1'b1 && t < 300);
         cmp({31'h0, RX_READY}, 32'h1);
         @(posedge CLK);
      end
      RX_VALID <= 1'b0;
   endtask
   task automatic tx_word(input logic [31:0] e, input logic l);
      // settle first: the edge that took the last word has not updated the outputs yet
      t = 0;
      do
      begin
         @(negedge CLK);
         t++;
      end
      while (!(TX_VALID === 1'b1 && TX_READY === 1'b1) && t < 300);
      cmp(TX_DATA, e);
      cmp({31'h0, TX_LAST}, {31'h0, l});
      @(posedge CLK);
   endtask
   ////////////////////////////////////////////////////////////
   initial
   begin
      CLK = 1'b0;
      forever #20 CLK = ~CLK;
   end
   initial
   begin
      #(40 * 30000);
      miscompares++;
      stop_test();
   end
   initial
   begin
      {SYS_RST, CE, REG_WR, REG_RD, RX_VALID, RX_EOF, RX_TOSS, TX_READY, TX_DONE} = 9'h180;
      {MAC_HALT_IMMEDIATE, MAC_TX_ENABLE, slow} = 3'h4;
      REG_ADDR = 8'h0;
      REG_WDATA = 32'h0;
      RX_DATA = 32'h0;
      TX_STATUS = 13'h0;
      miscompares = 0;
      tests_run = 0;
      repeat (20) @(posedge CLK);
      SYS_RST <= 1'b0;
      rd(A_RXLEN, 32'hffff_ffff, RXLEN_RST);
      rd(A_RXCTL, 32'hffff_ffff, 32'h0);
      rd(A_RXCNT, 32'hffff_ffff, 32'h0);
      // a write while the clock enable is low must leave the register alone
      CE <= 1'b0;
      wr(A_TXCTL, 32'h0000_0001);
      CE <= 1'b1;
      rd(A_TXCTL, 32'hffff_ffff, 32'h0);
      wr(8'h24, 32'hffff_ffff);
      rd(8'h24, 32'hffff_ffff, 32'h0);
      // two-entry receive ring, all owned by the engine
      mw(32'h100, 32'h1000);
      mw(32'h104, 32'h8000_0000);
      mw(32'h108, 32'h1400);
      mw(32'h10c, 32'h8000_0000);
      wr(A_RXLEN, 32'h0040_05ee);
      wr(A_RXPTR, 32'h100);
      wr(A_RXCTL, 32'h0000_0402);
      rx_frame(2, 32'ha0a0_0000, 1'b0);
      wown(32'h104);
      mc(32'h1000, 32'hffff_ffff, 32'ha0a0_0000);
      mc(32'h1004, 32'hffff_ffff, 32'ha0a0_0001);
      mc(32'h104, 32'hf7ff_ffff, 32'h3000_0008);
      rd(A_RXCNT, 32'hffff_ffff, 32'h1);
      rd(A_RXPTR, 32'hffff_ffff, 32'h100);
      rx_frame(1, 32'hb0b0_0000, 1'b1);
      wown(32'h10c);
      mc(32'h10c, 32'hf7ff_ffff, 32'h3020_0004);
      rd(A_RXCNT, 32'hffff_ffff, 32'h0);
      // 8-byte buffers force one frame across both entries, slow memory
      mw(32'h104, 32'h8000_0000);
      mw(32'h10c, 32'h8000_0000);
      slow <= 1'b1;
      wr(A_RXLEN, 32'h0008_05ee);
      rx_frame(3, 32'hc0c0_0000, 1'b0);
      wown(32'h10c);
      mc(32'h1400, 32'hffff_ffff, 32'hc0c0_0002);
      mc(32'h104, 32'ha800_ffff, 32'h2800_000c);
      mc(32'h10c, 32'h9000_ffff, 32'h1000_000c);
      slow <= 1'b0;
      // software-owned entry marked for skip
      wr(A_RXCTL, 32'h0000_0c02);
      mw(32'h104, 32'h4000_0000);
      mw(32'h10c, 32'h8000_0000);
      wr(A_RXLEN, 32'h0040_05ee);
      rx_frame(1, 32'hd0d0_0000, 1'b0);
      wown(32'h10c);
      mc(32'h1400, 32'hffff_ffff, 32'hd0d0_0000);
      mc(32'h104, 32'hffff_ffff, 32'h4000_0000);
      rd(A_STAT, 32'h1, 32'h0);
      // maximum frame of 8 bytes, four words sent
      mw(32'h100, 32'h1800);
      mw(32'h104, 32'h8000_0000);
      mw(32'h1808, 32'h5a5a_5a5a);
      wr(A_RXLEN, 32'h0040_0008);
      rx_frame(4, 32'he0e0_0000, 1'b0);
      wown(32'h104);
      mc(32'h1800, 32'hffff_ffff, 32'he0e0_0000);
      mc(32'h1804, 32'hffff_ffff, 32'he0e0_0003);
      mc(32'h1808, 32'hffff_ffff, 32'h5a5a_5a5a);
      mc(32'h104, 32'h8010_0000, 32'h0010_0000);
      // unowned entry without skip while halt option is set
      mw(32'h10c, 32'h0);
      wr(A_RXCTL, 32'h0000_0c02);
      RX_VALID <= 1'b1;
      RX_DATA <= 32'hf0f0_0000;
      RX_EOF <= 1'b1;
      repeat (60) @(negedge CLK);
      cmp({31'h0, RX_READY}, 32'h0);
      @(posedge CLK);
      RX_VALID <= 1'b0;
      rd(A_STAT, 32'h1, 32'h1);
      // transmit held by the MAC, then sent with the first word stalled
      mw(32'h200, 32'h1c00);
      mw(32'h204, 32'h8000_0008);
      mw(32'h20c, 32'h0);
      mw(32'h1c00, 32'h1111_2222);
      mw(32'h1c04, 32'h3333_4444);
      wr(A_TXPTR, 32'h200);
      wr(A_TXCTL, 32'h0000_0c02);
      t = 0;
      while (edd_mem_model_i.mem[32'h204 >> 2][28] !== 1'b1 && t < 600)
      begin
         @(negedge CLK);
         t++;
      end
      mc(32'h204, 32'h9000_0000, 32'h9000_0000);
      cmp({31'h0, TX_VALID}, 32'h0);
      @(posedge CLK);
      MAC_HALT_IMMEDIATE <= 1'b0;
      MAC_TX_ENABLE <= 1'b1;
      t = 0;
      while (TX_VALID !== 1'b1 && t < 600)
      begin
         @(negedge CLK);
         t++;
      end
      repeat (3) @(posedge CLK);
      TX_READY <= 1'b1;
      tx_word(32'h1111_2222, 1'b0);
      tx_word(32'h3333_4444, 1'b1);
      TX_DONE <= 1'b1;
      TX_STATUS <= 13'h0158;
      @(posedge CLK);
      TX_DONE <= 1'b0;
      wown(32'h204);
      mc(32'h204, 32'hffff_ffff, 32'h1560_0008);
      rd(A_TXCNT, 32'hffff_ffff, 32'h1);
      rd(A_STAT, 32'h2, 32'h2);
      rd(A_TXPTR, 32'hffff_ffff, 32'h200);
      stop_test();
   end
endmodule
`default_nettype wire
